// ===== hdl/pbrm_pkg.sv
// pbrm_pkg: constants shared by the binning and mirror stage
// assumes nothing of its surroundings
package pbrm_pkg;
  localparam int PBRM_PIX_W = 12;
  localparam int PBRM_SUM_W = 16;
  localparam int PBRM_MAX_COLS = 1024;
  localparam int PBRM_COL_W = 10;
  localparam logic [2:0] PBRM_BIN_OFF = 3'h1;
  localparam logic [2:0] PBRM_BIN_MAX = 3'h4;
  localparam logic [2:0] PBRM_BIN_RST = 3'h1;
  localparam logic PBRM_MIRROR_RST = 1'h0;
  localparam logic PBRM_MONO_RST = 1'h1;
  localparam int PBRM_CLK_MHZ = 10;
  localparam int PBRM_LAT_NS = 100;
  localparam int PBRM_LAT_CYC = (PBRM_LAT_NS * PBRM_CLK_MHZ + 999) / 1000;
endpackage

// ===== hdl/pbrm_sat_add.sv
// pbrm_sat_add: saturating adder of a partial sum and a new term
// assumes both operands are unsigned and the result width equals the operand width
`timescale 1ns/1ns
module pbrm_sat_add
  import pbrm_pkg::*;
#(
  parameter int W = PBRM_SUM_W
) (
  // operands
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  // result
  output logic [W-1:0] sum_o
);
  logic [W:0] full;
  always_comb begin
    full = {1'b0, a_i} + {1'b0, b_i};
    // clamp instead of wrapping, a bright bin must not turn dark
    sum_o = full[W] ? {W{1'b1}} : full[W-1:0];
  end
endmodule

// ===== hdl/pbrm_line_mem.sv
// pbrm_line_mem: flip-flop line store, one write port and one read port
// assumes the reader handles the one-cycle read latency
`timescale 1ns/1ns
module pbrm_line_mem
  import pbrm_pkg::*;
#(
  parameter int W = PBRM_SUM_W,
  parameter int D = PBRM_MAX_COLS,
  parameter int AW = PBRM_COL_W
) (
  // clock
  input wire logic mclk_i,
  // write side
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [W-1:0] wr_data_i,
  // read side
  input wire logic [AW-1:0] rd_addr_i,
  output logic [W-1:0] rd_data_o
);
  logic [W-1:0] mem [D];
  always_ff @(posedge mclk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule

// ===== hdl/pbrm_top.sv
// pbrm_top: vertical and horizontal binning with optional line mirroring
// assumes an upstream pixel stream on mclk_i with line and frame markers,
// lines no longer than MAX_COLS, and a gap between lines at least one line long
// when mirroring (the reversal buffer holds one binned line)
`timescale 1ns/1ns
module pbrm_top
  import pbrm_pkg::*;
#(
  parameter int PIX_W = PBRM_PIX_W,
  parameter int SUM_W = PBRM_SUM_W,
  parameter int MAX_COLS = PBRM_MAX_COLS,
  parameter int COL_W = PBRM_COL_W
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // configuration
  input wire logic [2:0] bin_vert_i,
  input wire logic [2:0] bin_horiz_i,
  input wire logic row_mirror_enable_i,
  input wire logic mono_variant_i,
  // sensor stream
  input wire logic pix_valid_i,
  input wire logic [PIX_W-1:0] pix_data_i,
  input wire logic frame_start_i,
  input wire logic line_end_i,
  // output stream
  output logic out_valid_o,
  output logic [SUM_W-1:0] out_data_o,
  output logic out_line_end_o,
  output logic out_frame_start_o,
  // status
  output logic [2:0] act_vert_o,
  output logic [2:0] act_horiz_o,
  output logic act_mirror_o,
  output logic [COL_W-1:0] binned_width_o,
  output logic [15:0] binned_lines_o
);
  typedef enum logic [1:0] {PBRM_IDLE, PBRM_PLAY} pbrm_play_t;

  typedef struct packed {
    logic [2:0] vf;
    logic [2:0] hf;
    logic mir;
    logic [2:0] hcnt;
    logic [2:0] vcnt;
    logic [SUM_W-1:0] hsum;
    logic [COL_W-1:0] col;
    logic [COL_W-1:0] wlen;
    logic [15:0] lines;
    logic sof_pend;
    logic fs_arm;
    pbrm_play_t play;
    logic [COL_W-1:0] rd_col;
    logic [COL_W-1:0] rd_len;
    logic rd_first;
    logic rd_v;
    logic rd_last;
    logic ov;
    logic [SUM_W-1:0] od;
    logic ole;
    logic ofs;
  } pbrm_state_t;

  pbrm_state_t s_r;
  pbrm_state_t s_nxt;

  // no combinational path from pins into the datapath: two-stage input sync
  logic [1:0] pv_s1_r, pv_s2_r, fs_s1_r, fs_s2_r, le_s1_r, le_s2_r;
  logic [PIX_W-1:0] pd_s1_r, pd_s2_r;
  logic [2:0] bv_s1_r, bv_s2_r, bh_s1_r, bh_s2_r;
  logic mi_s1_r, mi_s2_r, mo_s1_r, mo_s2_r;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pv_s1_r <= 2'h0;
      pv_s2_r <= 2'h0;
      fs_s1_r <= 2'h0;
      fs_s2_r <= 2'h0;
      le_s1_r <= 2'h0;
      le_s2_r <= 2'h0;
      pd_s1_r <= '0;
      pd_s2_r <= '0;
      bv_s1_r <= PBRM_BIN_RST;
      bv_s2_r <= PBRM_BIN_RST;
      bh_s1_r <= PBRM_BIN_RST;
      bh_s2_r <= PBRM_BIN_RST;
      mi_s1_r <= PBRM_MIRROR_RST;
      mi_s2_r <= PBRM_MIRROR_RST;
      mo_s1_r <= PBRM_MONO_RST;
      mo_s2_r <= PBRM_MONO_RST;
    end else begin
      pv_s1_r <= {1'b0, pix_valid_i};
      pv_s2_r <= pv_s1_r;
      fs_s1_r <= {1'b0, frame_start_i};
      fs_s2_r <= fs_s1_r;
      le_s1_r <= {1'b0, line_end_i};
      le_s2_r <= le_s1_r;
      pd_s1_r <= pix_data_i;
      pd_s2_r <= pd_s1_r;
      bv_s1_r <= bin_vert_i;
      bv_s2_r <= bv_s1_r;
      bh_s1_r <= bin_horiz_i;
      bh_s2_r <= bh_s1_r;
      mi_s1_r <= row_mirror_enable_i;
      mi_s2_r <= mi_s1_r;
      mo_s1_r <= mono_variant_i;
      mo_s2_r <= mo_s1_r;
    end
  end

  logic pv;
  logic fs;
  logic le;
  assign pv = pv_s2_r[0];
  assign fs = fs_s2_r[0];
  assign le = le_s2_r[0];

  // replace factor codes outside 1..4 with 1; color parts never bin
  function automatic logic [2:0] pbrm_legal(input logic [2:0] f, input logic mono);
    logic [2:0] r;
    r = f;
    if (f < PBRM_BIN_OFF || f > PBRM_BIN_MAX) begin
      r = PBRM_BIN_OFF;
    end
    if (!mono) begin
      r = PBRM_BIN_OFF;
    end
    return r;
  endfunction

  // horizontal add and vertical add
  logic [SUM_W-1:0] pix_ext;
  logic [SUM_W-1:0] hsum_add;
  logic [SUM_W-1:0] acc_rd;
  logic [SUM_W-1:0] vsum_add;
  logic [SUM_W-1:0] rev_rd;
  assign pix_ext = {{(SUM_W-PIX_W){1'b0}}, pd_s2_r};

  pbrm_sat_add #(.W(SUM_W)) u_hadd (
    .a_i(s_r.hcnt == 3'h0 ? '0 : s_r.hsum),
    .b_i(pix_ext),
    .sum_o(hsum_add)
  );

  // column bin complete; leftovers never reach this point
  logic hdone;
  assign hdone = pv && (s_r.hcnt + 3'h1 == s_r.hf);

  // the accumulator line is read one cycle ahead: the address is the next
  // column, so the partial sum is ready even when every pixel closes a bin
  pbrm_sat_add #(.W(SUM_W)) u_vadd (
    .a_i(s_r.vcnt == 3'h0 ? '0 : acc_rd),
    .b_i(hsum_add),
    .sum_o(vsum_add)
  );

  logic vlast;
  assign vlast = (s_r.vcnt + 3'h1 == s_r.vf);

  pbrm_line_mem #(.W(SUM_W), .D(MAX_COLS), .AW(COL_W)) u_acc (
    .mclk_i(mclk_i),
    .wr_en_i(hdone),
    .wr_addr_i(s_r.col),
    .wr_data_i(vsum_add),
    .rd_addr_i(s_nxt.col),
    .rd_data_o(acc_rd)
  );

  // reversal store: a completed binned line is written here, then replayed
  logic rev_we;
  assign rev_we = hdone && vlast && s_r.mir;

  pbrm_line_mem #(.W(SUM_W), .D(MAX_COLS), .AW(COL_W)) u_rev (
    .mclk_i(mclk_i),
    .wr_en_i(rev_we),
    .wr_addr_i(s_r.col),
    .wr_data_i(vsum_add),
    .rd_addr_i(s_r.rd_col),
    .rd_data_o(rev_rd)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.ov = 1'b0;
    s_nxt.ole = 1'b0;
    s_nxt.ofs = 1'b0;
    s_nxt.rd_v = 1'b0;
    s_nxt.rd_last = 1'b0;
    if (fs) begin
      // settings only change here, so a frame never mixes them
      s_nxt.vf = pbrm_legal(bv_s2_r, mo_s2_r);
      s_nxt.hf = pbrm_legal(bh_s2_r, mo_s2_r);
      s_nxt.mir = mi_s2_r;
      s_nxt.hcnt = 3'h0;
      s_nxt.vcnt = 3'h0;
      s_nxt.col = '0;
      s_nxt.lines = '0;
      s_nxt.sof_pend = 1'b1;
      s_nxt.play = PBRM_IDLE;
    end else begin
      if (pv) begin
        s_nxt.hsum = hsum_add;
        s_nxt.hcnt = hdone ? 3'h0 : s_r.hcnt + 3'h1;
      end
      if (hdone) begin
        s_nxt.col = s_r.col + COL_W'(1);
        if (vlast && !s_r.mir) begin
          s_nxt.ov = 1'b1;
          s_nxt.od = vsum_add;
          s_nxt.ofs = s_r.sof_pend;
          s_nxt.sof_pend = 1'b0;
        end
      end
      if (le) begin
        // partial column bin discarded with the line
        s_nxt.hcnt = 3'h0;
        s_nxt.col = '0;
        s_nxt.vcnt = vlast ? 3'h0 : s_r.vcnt + 3'h1;
        if (vlast && s_r.col != '0) begin
          // count of emitted lines is in binned units
          s_nxt.lines = s_r.lines + 16'h1;
          s_nxt.wlen = s_r.col + COL_W'(hdone);
          if (s_r.mir) begin
            s_nxt.play = PBRM_PLAY;
            s_nxt.rd_len = s_r.col + COL_W'(hdone);
            s_nxt.rd_col = s_r.col + COL_W'(hdone) - COL_W'(1);
            s_nxt.rd_first = 1'b1;
          end else if (s_nxt.ov) begin
            s_nxt.ole = 1'b1;
          end else begin
            s_nxt.ole = 1'b0;
          end
        end
      end
    end
    // replay the stored line last column first; window stays in sensor order
    unique case (s_r.play)
      PBRM_IDLE: begin
      end
      PBRM_PLAY: begin
        s_nxt.rd_v = 1'b1;
        s_nxt.rd_last = (s_r.rd_col == '0);
        s_nxt.rd_col = s_r.rd_col - COL_W'(1);
        if (s_r.rd_col == '0) begin
          s_nxt.play = PBRM_IDLE;
        end
      end
      default: begin
        s_nxt.play = PBRM_IDLE;
      end
    endcase
    if (s_r.rd_v) begin
      s_nxt.ov = 1'b1;
      s_nxt.od = rev_rd;
      s_nxt.ole = s_r.rd_last;
      s_nxt.ofs = s_r.sof_pend && s_r.rd_first;
      s_nxt.rd_first = 1'b0;
      if (s_r.rd_first) begin
        s_nxt.sof_pend = 1'b0;
      end
    end
  end

  // color variants have binning forced off: mono only bins, but mirroring is not gated by mono, so
  // the reversed store replays color lines as sampled, last column first, which swaps pixel phase on even widths
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r <= '{vf: PBRM_BIN_RST, hf: PBRM_BIN_RST, mir: PBRM_MIRROR_RST,
               play: PBRM_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  logic [2:0] avo_r, aho_r;
  logic amo_r;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
      out_line_end_o <= 1'b0;
      out_frame_start_o <= 1'b0;
      avo_r <= PBRM_BIN_RST;
      aho_r <= PBRM_BIN_RST;
      amo_r <= PBRM_MIRROR_RST;
      binned_width_o <= '0;
      binned_lines_o <= '0;
    end else begin
      out_valid_o <= s_r.ov;
      out_data_o <= s_r.od;
      out_line_end_o <= s_r.ole;
      out_frame_start_o <= s_r.ofs;
      avo_r <= s_r.vf;
      aho_r <= s_r.hf;
      amo_r <= s_r.mir;
      binned_width_o <= s_r.wlen;
      binned_lines_o <= s_r.lines;
    end
  end
  assign act_vert_o = avo_r;
  assign act_horiz_o = aho_r;
  assign act_mirror_o = amo_r;

  // vf, hf and mir keep their values on every cycle that follows a cycle without a frame start
  property p_frame_settings;
    @(posedge mclk_i) disable iff (!rst_b_i)
      !fs |=> $stable(s_r.vf) && $stable(s_r.hf) && $stable(s_r.mir);
  endproperty
  a_frame_settings: assert property (p_frame_settings) else $error("settings moved mid frame");

  property p_legal_factor;
    @(posedge mclk_i) disable iff (!rst_b_i)
      s_r.vf >= PBRM_BIN_OFF && s_r.vf <= PBRM_BIN_MAX && s_r.hf >= PBRM_BIN_OFF
      && s_r.hf <= PBRM_BIN_MAX;
  endproperty
  a_legal_factor: assert property (p_legal_factor) else $error("factor out of range");

  property p_color_nobin;
    @(posedge mclk_i) disable iff (!rst_b_i)
      fs && !mo_s2_r |=> s_r.vf == PBRM_BIN_OFF && s_r.hf == PBRM_BIN_OFF;
  endproperty
  a_color_nobin: assert property (p_color_nobin) else $error("color part binning");

  property p_hbin_count;
    @(posedge mclk_i) disable iff (!rst_b_i)
      hdone |-> s_r.hcnt == s_r.hf - 3'h1;
  endproperty
  a_hbin_count: assert property (p_hbin_count) else $error("column bin size wrong");

  property p_sat;
    @(posedge mclk_i) disable iff (!rst_b_i)
      pv && !fs && s_r.hcnt != 3'h0 |-> hsum_add >= s_r.hsum;
  endproperty
  a_sat: assert property (p_sat) else $error("sum wrapped");

  property p_vbin_emit;
    @(posedge mclk_i) disable iff (!rst_b_i)
      hdone && !fs && vlast && !s_r.mir |=> s_r.ov ##1 out_valid_o;
  endproperty
  a_vbin_emit: assert property (p_vbin_emit) else $error("binned pixel not emitted");

  sequence s_play_start;
    s_r.play == PBRM_IDLE ##1 s_r.play == PBRM_PLAY;
  endsequence
  property p_mirror_replay;
    @(posedge mclk_i) disable iff (!rst_b_i)
      s_play_start |-> s_r.mir;
  endproperty
  a_mirror_replay: assert property (p_mirror_replay) else $error("replay without mirror");

  property p_line_count;
    @(posedge mclk_i) disable iff (!rst_b_i)
      !fs && le && vlast && s_r.col != '0 |=> s_r.lines == $past(s_r.lines) + 16'h1;
  endproperty
  a_line_count: assert property (p_line_count) else $error("binned line count wrong");
endmodule

// ===== sim/pbrm_sensor_model.sv
// pbrm_sensor_model: sensor readout source feeding the binning stage
// assumes a free-running mclk_i and a caller that waits for reset release
`timescale 1ns/1ns
module pbrm_sensor_model
  import pbrm_pkg::*;
(
  // clock
  input wire logic mclk_i,
  // sensor stream
  output logic pix_valid_o,
  output logic [PBRM_PIX_W-1:0] pix_data_o,
  output logic frame_start_o,
  output logic line_end_o
);
  initial begin
    pix_valid_o = 1'h0;
    pix_data_o = 12'h000;
    frame_start_o = 1'h0;
    line_end_o = 1'h0;
  end

  function automatic logic [PBRM_PIX_W-1:0] pix(int r, int c, bit flat);
    return flat ? 12'hFFF : PBRM_PIX_W'(r * 64 + c * 3 + 1);
  endfunction

  task automatic send_frame(int cols, int rows, bit flat);
    @(posedge mclk_i) frame_start_o <= 1'h1;
    @(posedge mclk_i) frame_start_o <= 1'h0;
    for (int r = 0; r < rows; r++) begin
      for (int c = 0; c < cols; c++) begin
        pix_valid_o <= 1'h1;
        pix_data_o <= pix(r, c, flat);
        line_end_o <= (c == cols - 1);
        @(posedge mclk_i);
      end
      pix_valid_o <= 1'h0;
      line_end_o <= 1'h0;
      // idle data flips so a stale pixel can never pass as a real one
      pix_data_o <= ~pix_data_o;
      // gap longer than a line so the reversal buffer can replay
      repeat (cols + 8) @(posedge mclk_i);
    end
  endtask
endmodule

// ===== sim/pbrm_top_tb.sv
// pbrm_top_tb: frame-level checks of binning, mirroring and setting latch
// assumes the sensor model drives the stream and outputs are sampled on mclk_i
`timescale 1ns/1ns
module pbrm_top_tb;
  import pbrm_pkg::*;
  logic mclk_i = 1'h0;
  logic rst_b_i = 1'h0;
  logic [2:0] bin_vert_i = 3'h1;
  logic [2:0] bin_horiz_i = 3'h1;
  logic row_mirror_enable_i = 1'h0;
  logic mono_variant_i = 1'h1;
  logic pix_valid, frame_start, line_end;
  logic [PBRM_PIX_W-1:0] pix_data;
  logic out_valid_o, out_line_end_o, out_frame_start_o, act_mirror_o;
  logic [PBRM_SUM_W-1:0] out_data_o;
  logic [2:0] act_vert_o, act_horiz_o;
  logic [PBRM_COL_W-1:0] binned_width_o;
  logic [15:0] binned_lines_o;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  int fstarts = 0;
  int lends = 0;
  logic [15:0] got_q[$];
  logic [15:0] exp_q[$];

  always #50 mclk_i = ~mclk_i;

  pbrm_top u_pbrm_top (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .bin_vert_i(bin_vert_i),
    .bin_horiz_i(bin_horiz_i), .row_mirror_enable_i(row_mirror_enable_i),
    .mono_variant_i(mono_variant_i), .pix_valid_i(pix_valid), .pix_data_i(pix_data),
    .frame_start_i(frame_start), .line_end_i(line_end), .out_valid_o(out_valid_o),
    .out_data_o(out_data_o), .out_line_end_o(out_line_end_o),
    .out_frame_start_o(out_frame_start_o), .act_vert_o(act_vert_o),
    .act_horiz_o(act_horiz_o), .act_mirror_o(act_mirror_o),
    .binned_width_o(binned_width_o), .binned_lines_o(binned_lines_o));

  pbrm_sensor_model u_pbrm_sensor_model (.mclk_i(mclk_i), .pix_valid_o(pix_valid),
    .pix_data_o(pix_data), .frame_start_o(frame_start), .line_end_o(line_end));

  task automatic conclude();
    $display("checked %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // a hung drain is cut short here
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (out_valid_o === 1'h1) got_q.push_back(out_data_o);
    if (out_frame_start_o === 1'h1) fstarts++;
    if (out_line_end_o === 1'h1) lends++;
    if (cycles == 60000) begin
      failures++;
      conclude();
    end
  end

  task automatic check_pix(logic [15:0] got, logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error pixel at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_stat(logic [15:0] got, logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error status at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // chg moves both factors and the mirror setting in mid-frame; the frame must keep the old ones
  task automatic run(logic [2:0] v, logic [2:0] h, logic m, logic mo, int cols, int rows,
                     bit flat, bit chg);
    int vf, hf, w, s;
    logic [15:0] line[$];
    vf = (mo && v >= 3'h2 && v <= PBRM_BIN_MAX) ? int'(v) : 1;
    hf = (mo && h >= 3'h2 && h <= PBRM_BIN_MAX) ? int'(h) : 1;
    w = cols / hf;
    exp_q.delete();
    got_q.delete();
    fstarts = 0;
    lends = 0;
    for (int br = 0; br < rows / vf; br++) begin
      line.delete();
      for (int bc = 0; bc < w; bc++) begin
        s = 0;
        for (int i = 0; i < vf; i++)
          for (int j = 0; j < hf; j++)
            s += u_pbrm_sensor_model.pix(br * vf + i, bc * hf + j, flat);
        line.push_back(s > 65535 ? 16'hFFFF : 16'(s));
      end
      for (int k = 0; k < w; k++) exp_q.push_back(m ? line[w - 1 - k] : line[k]);
    end
    @(posedge mclk_i);
    bin_vert_i <= v;
    bin_horiz_i <= h;
    row_mirror_enable_i <= m;
    mono_variant_i <= mo;
    repeat (4) @(posedge mclk_i);
    fork
      u_pbrm_sensor_model.send_frame(cols, rows, flat);
      if (chg) begin
        repeat (10) @(posedge mclk_i);
        bin_vert_i <= 3'h3;
        bin_horiz_i <= 3'h3;
        row_mirror_enable_i <= ~m;
      end
    join
    for (int i = 0; i < 500 && got_q.size() < exp_q.size(); i++) @(posedge mclk_i);
    repeat (20) @(posedge mclk_i);
    check_stat(16'(got_q.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) check_pix(i < got_q.size() ? got_q[i] : ~exp_q[i], exp_q[i]);
    check_stat({13'h0000, act_vert_o}, 16'(vf));
    check_stat({13'h0000, act_horiz_o}, 16'(hf));
    check_stat({15'h0000, act_mirror_o}, {15'h0000, m});
    check_stat({6'h00, binned_width_o}, 16'(w));
    check_stat(binned_lines_o, 16'(rows / vf));
    check_stat(16'(fstarts), 16'h0001);
    // unmirrored lines only mark their end when the last pixel closes a bin
    check_stat(16'(lends), (m || cols % hf == 0) ? 16'(rows / vf) : 16'h0000);
    $display("test done: v %0d h %0d mirror %0d mono %0d", v, h, m, mo);
  endtask

  initial begin
    repeat (6) @(posedge mclk_i);
    rst_b_i <= 1'h1;
    repeat (2) @(posedge mclk_i);
    run(3'h1, 3'h1, 1'h0, 1'h1, 8, 4, 0, 0);
    run(3'h2, 3'h1, 1'h0, 1'h1, 8, 5, 0, 0);
    run(3'h3, 3'h1, 1'h0, 1'h1, 7, 7, 0, 0);
    run(3'h4, 3'h1, 1'h0, 1'h1, 6, 9, 0, 0);
    run(3'h1, 3'h2, 1'h0, 1'h1, 9, 2, 0, 0);
    run(3'h1, 3'h3, 1'h0, 1'h1, 10, 2, 0, 0);
    run(3'h1, 3'h4, 1'h0, 1'h1, 11, 2, 0, 0);
    run(3'h2, 3'h3, 1'h0, 1'h1, 9, 4, 0, 0);
    run(3'h1, 3'h1, 1'h1, 1'h1, 8, 2, 0, 0);
    run(3'h2, 3'h2, 1'h1, 1'h1, 10, 4, 0, 0);
    run(3'h4, 3'h4, 1'h0, 1'h0, 8, 4, 0, 0);
    run(3'h5, 3'h0, 1'h0, 1'h1, 6, 2, 0, 0);
    run(3'h4, 3'h4, 1'h0, 1'h1, 8, 4, 1, 0);
    run(3'h2, 3'h2, 1'h0, 1'h1, 8, 4, 0, 1);
    conclude();
  end
endmodule
